// [pkg/acq_counter_consts.svh]
`ifndef ACQ_COUNTER_CONSTS_SVH
`define ACQ_COUNTER_CONSTS_SVH

// Register byte addresses (Avalon word aligned, except REG_LOW_RB at 8'h03)
`define REG_LOW_RB      8'h03
`define REG_HIGH_RB     8'h04
`define REG_LOAD_CTRL   8'h08
`define REG_MEM_CTRL    8'h0c
`define REG_CLK_SEL     8'h10
`define REG_STEP        8'h14
`define REG_TEST_DATA   8'h18
`define REG_IRQ_STATUS  8'h1c
`define REG_IRQ_MASK    8'h20

// Field positions
`define LOAD_LOW_BIT    3
`define LOAD_HIGH_BIT   4
`define MEM_RD_BIT      5
`define CLK_SEL_BIT     7
`define FULL_RB_BIT     7
`define IRQ_FULL_BIT    0
`define IRQ_WRAP_BIT    1

// Reset values
`define LOAD_CTRL_RST   8'hff
`define MEM_CTRL_RST    8'h00
`define CLK_SEL_RST     1'b0

// Geometry
`define ADDR_BITS       10
`define CNT_BITS        12
`define MEM_WORDS       1024
`define MEM_WIDTH       24

`endif

// [pkg/acq_counter_pkg.sv]
package acq_counter_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;
endpackage

// [design/step_pulse_gen.sv]
`timescale 1ns/100ps
// One counter clock pulse per step write, only while clock_source_sel is set and gated
module step_pulse_gen (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic step_write,
  input  wire logic clock_source_sel,
  input  wire logic counter_load_gate_n,
  output logic      counter_clock
);
  wire pulse_nxt = step_write & clock_source_sel & ~counter_load_gate_n;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      counter_clock <= 1'b0;
    end else begin
      counter_clock <= pulse_nxt;
    end
  end
endmodule

// [design/wrap_flag.sv]
`timescale 1ns/100ps
// Memory-full flag: set by terminal count, cleared by low-byte load
module wrap_flag (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic wrap_event,
  input  wire logic clear_load,
  output logic      full_flag
);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      full_flag <= 1'b0;
    end else if (clear_load) begin
      full_flag <= 1'b0;
    end else if (wrap_event) begin
      full_flag <= 1'b1;
    end
  end
endmodule

// [design/acq_address_counter.sv]
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/100ps
`include "acq_counter_consts.svh"
module acq_address_counter
  import acq_counter_pkg::*;
#(
  parameter int MEM_WORDS = `MEM_WORDS,
  parameter int MEM_WIDTH = `MEM_WIDTH
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [9:0]       mem_address,
  output logic             irq
);
  bus_state_t           state_r;
  logic [7:0]           load_ctrl_r;
  logic [7:0]           mem_ctrl_r;
  logic                 clk_sel_r;
  logic [7:0]           test_data_r;
  logic [1:0]           irq_status_r;
  logic [1:0]           irq_mask_r;
  logic [`CNT_BITS-1:0] count_r;
  logic                 gate_n_r;
  logic [31:0]          rdata_nxt;
  logic                 counter_clock;
  logic                 full_flag;

  wire req      = (avs_read | avs_write) & (state_r == BUS_IDLE);
  // Writes act at the answer edge, the one edge at which the master sees the handshake
  wire ack      = (state_r == BUS_ACK);
  wire wr_acc   = ack & avs_write & avs_byteenable[0];
  wire wr_load  = wr_acc & (avs_address == `REG_LOAD_CTRL);
  wire wr_mem   = wr_acc & (avs_address == `REG_MEM_CTRL);
  wire wr_clk   = wr_acc & (avs_address == `REG_CLK_SEL);
  wire wr_step  = wr_acc & (avs_address == `REG_STEP);
  wire wr_data  = wr_acc & (avs_address == `REG_TEST_DATA);
  wire wr_stat  = wr_acc & (avs_address == `REG_IRQ_STATUS);
  wire wr_mask  = wr_acc & (avs_address == `REG_IRQ_MASK);

  wire low_load_n  = load_ctrl_r[`LOAD_LOW_BIT];
  wire high_load_n = load_ctrl_r[`LOAD_HIGH_BIT];
  // Upper two bits are hard-wired high
  wire [`CNT_BITS-1:0] loaded = {2'b11,
    high_load_n ? count_r[9:8] : test_data_r[1:0],
    low_load_n ? count_r[7:0] : test_data_r};
  wire [`CNT_BITS-1:0] incr = {2'b11, count_r[9:0] + 10'h001};
  wire counting = low_load_n & high_load_n;
  wire [`CNT_BITS-1:0] count_nxt = counting ? incr : loaded;
  // Terminal count inverted clocks the flag only on a counting step
  wire wrap_event = counter_clock & counting & (count_r == 12'hfff);
  wire [1:0] irq_events = {wrap_event & ~full_flag, wrap_event};

  wire [7:0] high_rb = {full_flag, 5'h00, count_r[9:8]};
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (avs_address)
      `REG_LOW_RB:     rdata_nxt = {24'h00_0000, count_r[7:0]};
      `REG_HIGH_RB:    rdata_nxt = {24'h00_0000, high_rb};
      `REG_LOAD_CTRL:  rdata_nxt = {24'h00_0000, load_ctrl_r};
      `REG_MEM_CTRL:   rdata_nxt = {24'h00_0000, mem_ctrl_r};
      `REG_CLK_SEL:    rdata_nxt = {31'h0000_0000, clk_sel_r};
      `REG_TEST_DATA:  rdata_nxt = {24'h00_0000, test_data_r};
      `REG_IRQ_STATUS: rdata_nxt = {30'h0000_0000, irq_status_r};
      `REG_IRQ_MASK:   rdata_nxt = {30'h0000_0000, irq_mask_r};
      default:         rdata_nxt = 32'h0000_0000;
    endcase
  end

  // One wait cycle per request; unmapped reads return zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r         <= BUS_IDLE;
      avs_readdata    <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else if (req) begin
      state_r         <= BUS_ACK;
      avs_readdata    <= rdata_nxt;
      avs_waitrequest <= 1'b0;
    end else begin
      state_r         <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      load_ctrl_r <= `LOAD_CTRL_RST;
      mem_ctrl_r  <= `MEM_CTRL_RST;
      clk_sel_r   <= `CLK_SEL_RST;
      test_data_r <= 8'h00;
      irq_mask_r  <= 2'b00;
    end else begin
      if (wr_load) load_ctrl_r <= avs_writedata[7:0];
      if (wr_mem)  mem_ctrl_r  <= avs_writedata[7:0];
      if (wr_clk)  clk_sel_r   <= avs_writedata[`CLK_SEL_BIT];
      if (wr_data) test_data_r <= avs_writedata[7:0];
      if (wr_mask) irq_mask_r  <= avs_writedata[1:0];
    end
  end

  // Set wins over the write-one clear
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_status_r <= 2'b00;
    end else begin
      irq_status_r <= (irq_status_r & ~({2{wr_stat}} & avs_writedata[1:0])) | irq_events;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      gate_n_r <= 1'b1;
      irq      <= 1'b0;
    end else begin
      gate_n_r <= ~mem_ctrl_r[`MEM_RD_BIT];
      irq      <= |(irq_status_r & irq_mask_r);
    end
  end

  // No reset documented for the count; 12'hc00 (address zero) is a neutral start
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_r <= 12'hc00;
    end else if (counter_clock) begin
      count_r <= count_nxt;
    end
  end
  assign mem_address = count_r[9:0];

  step_pulse_gen u_step (
    .clk_sys             (clk_sys),
    .reset               (reset),
    .step_write          (wr_step),
    .clock_source_sel    (clk_sel_r),
    .counter_load_gate_n (gate_n_r),
    .counter_clock       (counter_clock)
  );

  wrap_flag u_flag (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .wrap_event (wrap_event),
    .clear_load (~low_load_n),
    .full_flag  (full_flag)
  );
endmodule

// [dv/host_model.sv]
`timescale 1ns/100ps
// Host side of the register bus; one request at a time, held until answered
module host_model (
  input  wire logic        clk_sys,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output logic [7:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable
);
  initial begin
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    avs_byteenable = 4'hf;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 40) begin
      acq_address_counter_bench.errors++;
      acq_address_counter_bench.end_of_test();
    end
  endtask
endmodule

// [dv/acq_address_counter_sva.sv]
`timescale 1ns/100ps
module acq_address_counter_sva #(
  parameter int MEM_WORDS = 1024,
  parameter int MEM_WIDTH = 24
) (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic [9:0]  mem_address
);
  logic [7:0] load_ctrl_r;
  // Shadow of the load-control register, seen only from accepted writes
  always_ff @(posedge clk_sys or posedge reset)
    if (reset) load_ctrl_r <= 8'hff;
    else if (avs_write && !avs_waitrequest && avs_address == 8'h08)
      load_ctrl_r <= avs_writedata[7:0];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_rd(a); avs_read && !avs_waitrequest && avs_address == a; endsequence
  chk_answer_bound: assert property (s_req |-> ##[0:3] !avs_waitrequest)
    else $error("request not answered");
  chk_wait_pulse: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("answer held too long");
  chk_answer_cause: assert property (!avs_waitrequest |-> avs_read || avs_write)
    else $error("answer without request");
  chk_low_readback: assert property (s_rd(8'h03) |-> avs_readdata[7:0] == mem_address[7:0])
    else $error("low readback wrong");
  chk_high_readback: assert property (s_rd(8'h04)
    |-> avs_readdata[6:0] == {5'h00, mem_address[9:8]}) else $error("high readback wrong");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && !(avs_address inside
    {8'h03, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20}) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_count_cause: assert property (!$stable(mem_address)
    |-> $past(avs_write, 1) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("count moved without a write");
  chk_count_step: assert property (!$stable(mem_address) && load_ctrl_r == 8'hff
    |-> mem_address == $past(mem_address) + 10'h001) else $error("count did not step by one");
endmodule
bind acq_address_counter acq_address_counter_sva #(.MEM_WORDS(MEM_WORDS), .MEM_WIDTH(MEM_WIDTH))
  chk (
    .clk_sys         (clk_sys),
    .reset           (reset),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_waitrequest (avs_waitrequest),
    .avs_readdata    (avs_readdata),
    .mem_address     (mem_address)
  );

// [dv/acq_address_counter_bench.sv]
`timescale 1ns/100ps
`include "acq_counter_consts.svh"
module acq_address_counter_bench;
  logic        clk_sys, reset, avs_read, avs_write, avs_waitrequest, irq;
  logic [7:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [9:0]  mem_address;
  int          errors = 0;
  int          n_checks = 0;
  host_model h (
    .clk_sys         (clk_sys),
    .avs_waitrequest (avs_waitrequest),
    .avs_readdata    (avs_readdata),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable)
  );
  acq_address_counter dut (
    .clk_sys         (clk_sys),
    .reset           (reset),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .mem_address     (mem_address),
    .irq             (irq)
  );
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); h.xfer(1'b1, a, d, q); endtask
  task rd(input logic [7:0] a); h.xfer(1'b0, a, 32'h0, q); endtask
  task rdcnt(input logic [9:0] v, input logic f);
    rd(`REG_LOW_RB);
    check(q, {24'h0, v[7:0]});
    rd(`REG_HIGH_RB);
    check(q, {24'h0, f, 5'h00, v[9:8]});
  endtask
  task load(input logic [9:0] v);
    wr(`REG_LOAD_CTRL, 32'hf7);
    wr(`REG_TEST_DATA, {24'h0, v[7:0]});
    wr(`REG_STEP, 32'h0);
    wr(`REG_LOAD_CTRL, 32'hef);
    wr(`REG_TEST_DATA, {30'h0, v[9:8]});
    wr(`REG_STEP, 32'h0);
    wr(`REG_LOAD_CTRL, 32'hff);
  endtask
  task t_setup;
    // Step with the gate still closed must leave the count alone
    wr(`REG_STEP, 32'h0);
    rdcnt(10'h000, 1'b0);
    wr(`REG_CLK_SEL, 32'h80);
    wr(`REG_MEM_CTRL, 32'h20);
    wr(`REG_IRQ_MASK, 32'h1);
  endtask
  task t_count;
    load(10'h000);
    rdcnt(10'h000, 1'b0);
    for (int i = 1; i < 1024 && errors == 0; i++) begin
      wr(`REG_STEP, 32'h0);
      rdcnt(i[9:0], 1'b0);
    end
  endtask
  task t_full;
    load(10'h3ff);
    rdcnt(10'h3ff, 1'b0);
    check({31'h0, irq}, 32'h0);
    wr(`REG_STEP, 32'h0);
    rdcnt(10'h000, 1'b1);
    check({31'h0, irq}, 32'h1);
    rd(`REG_IRQ_STATUS);
    check(q, 32'h3);
    wr(`REG_IRQ_STATUS, 32'h3);
    wr(`REG_IRQ_MASK, 32'h0);
    load(10'h3ff);
    rdcnt(10'h3ff, 1'b0);
    wr(`REG_STEP, 32'h0);
    rd(`REG_IRQ_STATUS);
    check(q, 32'h3);
    check({31'h0, irq}, 32'h0);
    rd(8'h40);
    check(q, 32'h0);
  endtask
  task end_of_test;
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    t_setup;
    t_count;
    t_full;
    end_of_test;
  end
endmodule
